// ===== core/psar_map.svh
`ifndef PSAR_MAP_SVH
`define PSAR_MAP_SVH

// Register word offsets on the Avalon-MM slave (byte addresses).
`define PSAR_OFS_FAULT_ADDR   6'h00
`define PSAR_OFS_DIR_BASE     6'h04
`define PSAR_OFS_GLOBAL_BASE  6'h08
`define PSAR_OFS_GLOBAL_LIMIT 6'h0C
`define PSAR_OFS_INTR_BASE    6'h10
`define PSAR_OFS_INTR_LIMIT   6'h14
`define PSAR_OFS_LOCAL_SEL    6'h18
`define PSAR_OFS_TASK_SEL     6'h1C
`define PSAR_OFS_CONTROL      6'h20
`define PSAR_OFS_STATUS       6'h24

// Directory base register layout.
`define PSAR_DIR_BASE_MASK    32'hFFFFF000
`define PSAR_DIR_WRITE_MASK   32'hFFFFF018
`define PSAR_BIT_CACHE_DIS    4
`define PSAR_BIT_WRITE_THRU   3

// Control register layout.
`define PSAR_BIT_PAGING_EN    0

// Reset values.
`define PSAR_RST_WORD         32'h00000000
`define PSAR_RST_HALF         16'h0000

`endif

// ===== core/psar_pkg.sv
package psar_pkg;

  typedef enum logic [1:0] {
    PSAR_SRC_DIR_BASE  = 2'h0,
    PSAR_SRC_DIR_ENTRY = 2'h1,
    PSAR_SRC_TBL_ENTRY = 2'h2
  } psar_attr_src_t;

  typedef enum logic [2:0] {
    PSAR_ST_IDLE = 3'h1,
    PSAR_ST_RESP = 3'h2,
    PSAR_ST_DONE = 3'h4
  } psar_bus_state_t;

endpackage

// ===== core/psar_regs.sv
`timescale 1ns/100ps
`include "psar_map.svh"

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - A detected page fault loads its linear address into the fault address register.
// - When the fault handler starts, an error code describing the fault is pushed out.
// - The directory base keeps only address bits 31-12, so it is 4 Kbyte aligned.
// - Writable cache-disable bit 4 and write-through bit 3 drive pins on external page access.
// - The attributes come from the directory base, a directory entry or a table entry.
// - With paging disabled both cacheability attributes read as zero on the pins.
// - Any write to the directory base, or a task switch changing it, flushes the TLB.
// - The directory base is used directly as a physical address, untranslated.
// - The global table register holds a 32-bit base in 47-16 and a 16-bit limit in 15-0.
// - The interrupt table register has the same 32-bit base and 16-bit limit layout.
// - Global and interrupt table bases are linear and go through translation when paging.
// - The local table register holds a writable 16-bit selector.
// - The task segment register holds a 16-bit selector.
module psar_regs (
  input  wire logic        clk,
  input  wire logic        nrst,
  // Avalon-MM slave.
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic      [1:0]  avs_response,
  output logic             avs_waitrequest,
  // Core side.
  input  wire logic        fault_valid,
  input  wire logic [31:0] fault_linear_addr,
  input  wire logic [31:0] fault_error_code,
  input  wire logic        handler_invoke,
  input  wire logic        task_switch,
  input  wire logic [31:0] task_dir_base,
  input  wire logic [1:0]  attr_src,
  input  wire logic [1:0]  dir_entry_attr,
  input  wire logic [1:0]  tbl_entry_attr,
  input  wire logic        dir_entry_update,
  input  wire logic        ext_page_access,
  output logic             page_cache_disable,
  output logic             page_write_through,
  output logic             tlb_flush,
  output logic      [31:0] dir_phys_addr,
  output logic      [31:0] global_base_out,
  output logic      [31:0] interrupt_base_out,
  output logic             table_translate,
  output logic             err_push_valid,
  output logic      [31:0] err_push_data,
  output logic      [15:0] local_selector_out,
  output logic      [15:0] task_selector_out
);

  ////////////////////////////////////////////////////////////////////////////////

  logic [31:0]                 page_fault_address_reg;
  logic [31:0]                 page_directory_base_reg;
  logic [47:0]                 global_table_base_limit_reg;
  logic [47:0]                 interrupt_table_base_limit_reg;
  logic [15:0]                 local_table_selector_reg;
  logic [15:0]                 task_segment_selector_reg;
  logic                        paging_enable_reg;
  logic                        tlb_flush_reg;
  logic [31:0]                 err_push_data_reg;
  logic                        err_push_valid_reg;
  logic [31:0]                 readdata_reg;
  logic                        slverr_reg;
  psar_pkg::psar_bus_state_t   state_reg;
  psar_pkg::psar_bus_state_t   state_next;
  logic                        wr_take;
  logic                        rd_take;
  logic [31:0]                 dir_base_next;
  logic                        cd_sel;
  logic                        wt_sel;

  // Byte-lane merge used by every writable register except the control register.
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Bus handshake: an access starting in idle takes exactly one wait cycle (one right after another takes two), so that the answer
  // is registered and the bus output never depends combinationally on the address.

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      psar_pkg::PSAR_ST_IDLE: begin
        if (avs_read || avs_write) begin
          state_next = psar_pkg::PSAR_ST_RESP;
        end
      end
      psar_pkg::PSAR_ST_RESP: state_next = psar_pkg::PSAR_ST_DONE;
      psar_pkg::PSAR_ST_DONE: state_next = psar_pkg::PSAR_ST_IDLE;
      default:                state_next = psar_pkg::PSAR_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= psar_pkg::PSAR_ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign wr_take         = (state_reg == psar_pkg::PSAR_ST_RESP) && avs_write;
  assign rd_take         = (state_reg == psar_pkg::PSAR_ST_RESP) && avs_read;
  assign avs_waitrequest = (avs_read || avs_write) && (state_reg != psar_pkg::PSAR_ST_RESP);
  assign avs_readdata    = readdata_reg;
  assign avs_response    = slverr_reg ? 2'h2 : 2'h0;

  ////////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      readdata_reg <= `PSAR_RST_WORD;
      slverr_reg   <= 1'b0;
    end else if (state_reg == psar_pkg::PSAR_ST_IDLE && (avs_read || avs_write)) begin
      slverr_reg <= 1'b0;
      unique case (avs_address)
        `PSAR_OFS_FAULT_ADDR:   readdata_reg <= page_fault_address_reg;
        `PSAR_OFS_DIR_BASE:     readdata_reg <= page_directory_base_reg;
        `PSAR_OFS_GLOBAL_BASE:  readdata_reg <= global_table_base_limit_reg[47:16];
        `PSAR_OFS_GLOBAL_LIMIT: readdata_reg <= {16'h0000, global_table_base_limit_reg[15:0]};
        `PSAR_OFS_INTR_BASE:    readdata_reg <= interrupt_table_base_limit_reg[47:16];
        `PSAR_OFS_INTR_LIMIT:   readdata_reg <= {16'h0000, interrupt_table_base_limit_reg[15:0]};
        `PSAR_OFS_LOCAL_SEL:    readdata_reg <= {16'h0000, local_table_selector_reg};
        `PSAR_OFS_TASK_SEL:     readdata_reg <= {16'h0000, task_segment_selector_reg};
        `PSAR_OFS_CONTROL:      readdata_reg <= {31'h00000000, paging_enable_reg};
        `PSAR_OFS_STATUS:       readdata_reg <= {31'h00000000, tlb_flush_reg};
        default: begin
          readdata_reg <= `PSAR_RST_WORD;
          slverr_reg   <= 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // A hardware fault capture wins over a software write in the same cycle.

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      page_fault_address_reg <= `PSAR_RST_WORD;
    end else if (fault_valid) begin
      page_fault_address_reg <= fault_linear_addr;
    end else if (wr_take && avs_address == `PSAR_OFS_FAULT_ADDR) begin
      page_fault_address_reg <= lane_merge(page_fault_address_reg, avs_writedata, avs_byteenable);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      err_push_valid_reg <= 1'b0;
      err_push_data_reg  <= `PSAR_RST_WORD;
    end else begin
      err_push_valid_reg <= handler_invoke;
      if (handler_invoke) begin
        err_push_data_reg <= fault_error_code;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Directory base: a software write wins over a task switch landing together.

  always_comb begin
    dir_base_next = page_directory_base_reg;
    if (wr_take && avs_address == `PSAR_OFS_DIR_BASE) begin
      dir_base_next = lane_merge(page_directory_base_reg, avs_writedata, avs_byteenable);
    end else if (task_switch) begin
      dir_base_next = task_dir_base;
    end
    dir_base_next = dir_base_next & `PSAR_DIR_WRITE_MASK;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      page_directory_base_reg <= `PSAR_RST_WORD;
      tlb_flush_reg           <= 1'b0;
    end else begin
      page_directory_base_reg <= dir_base_next;
      tlb_flush_reg <= (wr_take && avs_address == `PSAR_OFS_DIR_BASE) ||
                       (task_switch && dir_base_next != page_directory_base_reg);
    end
  end

  assign tlb_flush     = tlb_flush_reg;
  assign dir_phys_addr = page_directory_base_reg & `PSAR_DIR_BASE_MASK;

  ////////////////////////////////////////////////////////////////////////////////
  // Cacheability attribute selection; bit 1 of each entry pair is cache-disable.

  always_comb begin
    cd_sel = page_directory_base_reg[`PSAR_BIT_CACHE_DIS];
    wt_sel = page_directory_base_reg[`PSAR_BIT_WRITE_THRU];
    if (!dir_entry_update) begin
      if (attr_src == psar_pkg::PSAR_SRC_DIR_ENTRY) begin
        cd_sel = dir_entry_attr[1];
        wt_sel = dir_entry_attr[0];
      end else if (attr_src == psar_pkg::PSAR_SRC_TBL_ENTRY) begin
        cd_sel = tbl_entry_attr[1];
        wt_sel = tbl_entry_attr[0];
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      page_cache_disable <= 1'b0;
      page_write_through <= 1'b0;
    end else if (!paging_enable_reg) begin
      page_cache_disable <= 1'b0;
      page_write_through <= 1'b0;
    end else if (ext_page_access) begin
      page_cache_disable <= cd_sel;
      page_write_through <= wt_sel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      global_table_base_limit_reg    <= {`PSAR_RST_WORD, `PSAR_RST_HALF};
      interrupt_table_base_limit_reg <= {`PSAR_RST_WORD, `PSAR_RST_HALF};
      local_table_selector_reg       <= `PSAR_RST_HALF;
      task_segment_selector_reg      <= `PSAR_RST_HALF;
      paging_enable_reg              <= 1'b0;
    end else if (wr_take) begin
      unique case (avs_address)
        `PSAR_OFS_GLOBAL_BASE: global_table_base_limit_reg[47:16] <=
          lane_merge(global_table_base_limit_reg[47:16], avs_writedata, avs_byteenable);
        `PSAR_OFS_GLOBAL_LIMIT: global_table_base_limit_reg[15:0] <= 16'(lane_merge(
          {16'h0000, global_table_base_limit_reg[15:0]}, avs_writedata, avs_byteenable));
        `PSAR_OFS_INTR_BASE: interrupt_table_base_limit_reg[47:16] <=
          lane_merge(interrupt_table_base_limit_reg[47:16], avs_writedata,
                     avs_byteenable);
        `PSAR_OFS_INTR_LIMIT: interrupt_table_base_limit_reg[15:0] <= 16'(lane_merge(
          {16'h0000, interrupt_table_base_limit_reg[15:0]}, avs_writedata, avs_byteenable));
        `PSAR_OFS_LOCAL_SEL: local_table_selector_reg <= 16'(lane_merge(
          {16'h0000, local_table_selector_reg}, avs_writedata, avs_byteenable));
        `PSAR_OFS_TASK_SEL: task_segment_selector_reg <= 16'(lane_merge(
          {16'h0000, task_segment_selector_reg}, avs_writedata, avs_byteenable));
        `PSAR_OFS_CONTROL: if (avs_byteenable[0]) begin
          paging_enable_reg <= avs_writedata[`PSAR_BIT_PAGING_EN];
        end
        default: ;
      endcase
    end
  end

  assign global_base_out    = global_table_base_limit_reg[47:16];
  assign interrupt_base_out = interrupt_table_base_limit_reg[47:16];
  assign table_translate    = paging_enable_reg;
  assign local_selector_out = local_table_selector_reg;
  assign task_selector_out  = task_segment_selector_reg;
  assign err_push_valid     = err_push_valid_reg;
  assign err_push_data      = err_push_data_reg;

  ////////////////////////////////////////////////////////////////////////////////

  fault_capture_a: assert property (@(posedge clk) disable iff (!nrst)
    fault_valid |=> page_fault_address_reg == $past(fault_linear_addr))
    else $error("Fault address not captured.");

  err_push_a: assert property (@(posedge clk) disable iff (!nrst)
    handler_invoke |=> err_push_valid && err_push_data == $past(fault_error_code))
    else $error("Error code not pushed.");

  dir_align_a: assert property (@(posedge clk) disable iff (!nrst)
    dir_phys_addr[11:0] == 12'h000)
    else $error("Directory base not aligned.");

  attr_drive_a: assert property (@(posedge clk) disable iff (!nrst)
    (paging_enable_reg && ext_page_access && dir_entry_update) |=>
      page_cache_disable == $past(page_directory_base_reg[`PSAR_BIT_CACHE_DIS]) &&
      page_write_through == $past(page_directory_base_reg[`PSAR_BIT_WRITE_THRU]))
    else $error("Attribute pins not driven from directory base.");

  attr_entry_a: assert property (@(posedge clk) disable iff (!nrst)
    (paging_enable_reg && ext_page_access && !dir_entry_update &&
     attr_src == psar_pkg::PSAR_SRC_TBL_ENTRY) |=>
      {page_cache_disable, page_write_through} == $past(tbl_entry_attr))
    else $error("Table entry attributes not used.");

  attr_off_a: assert property (@(posedge clk) disable iff (!nrst)
    !paging_enable_reg |=> !page_cache_disable && !page_write_through)
    else $error("Attributes not zero with paging off.");

  tlb_flush_a: assert property (@(posedge clk) disable iff (!nrst)
    (wr_take && avs_address == `PSAR_OFS_DIR_BASE) |=> tlb_flush)
    else $error("Directory write did not flush TLB.");

  rsvd_zero_a: assert property (@(posedge clk) disable iff (!nrst)
    (page_directory_base_reg & ~`PSAR_DIR_WRITE_MASK) == 32'h00000000)
    else $error("Reserved directory bits set.");

  wait_one_a: assert property (@(posedge clk) disable iff (!nrst)
    ($rose(avs_read) && state_reg == psar_pkg::PSAR_ST_IDLE) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("Bus answer not after one wait cycle.");

  attr_hold_a: assert property (@(posedge clk) disable iff (!nrst)
    (paging_enable_reg && !ext_page_access) |=>
      $stable({page_cache_disable, page_write_through}))
    else $error("Attribute pins changed without a page access.");

  dir_entry_a: assert property (@(posedge clk) disable iff (!nrst)
    (paging_enable_reg && ext_page_access && !dir_entry_update &&
     attr_src == psar_pkg::PSAR_SRC_DIR_ENTRY) |=>
      {page_cache_disable, page_write_through} == $past(dir_entry_attr))
    else $error("Directory entry attributes not used.");

  flush_task_a: assert property (@(posedge clk) disable iff (!nrst)
    (task_switch && (task_dir_base & `PSAR_DIR_WRITE_MASK) != page_directory_base_reg)
      |=> tlb_flush)
    else $error("Task switch changing the directory base did not flush TLB.");

  flush_cause_a: assert property (@(posedge clk) disable iff (!nrst)
    (!task_switch && !(wr_take && avs_address == `PSAR_OFS_DIR_BASE)) |=> !tlb_flush)
    else $error("TLB flushed without a directory base load.");

  dir_phys_a: assert property (@(posedge clk) disable iff (!nrst)
    dir_phys_addr[31:12] == page_directory_base_reg[31:12])
    else $error("Directory physical address not taken from the register.");

  err_pulse_a: assert property (@(posedge clk) disable iff (!nrst)
    !handler_invoke |=> !err_push_valid)
    else $error("Error code push without a handler start.");

  // A flush follows its task switch by one cycle, so the cover looks one edge later.
  fault_cov_c: cover property (@(posedge clk) disable iff (!nrst) fault_valid);
  flush_cov_c: cover property (@(posedge clk) disable iff (!nrst) task_switch ##1 tlb_flush);
  attr_cov_c:  cover property (@(posedge clk) disable iff (!nrst) page_cache_disable);
  hold_cov_c:  cover property (@(posedge clk) disable iff (!nrst)
    paging_enable_reg && !ext_page_access);
  err_cov_c:   cover property (@(posedge clk) disable iff (!nrst) err_push_valid);

endmodule

// ===== tb/tb_psar.sv
`timescale 1ns/100ps
`include "psar_map.svh"

module tb;
  logic        clk;
  logic        nrst;
  logic [5:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic [1:0]  avs_response;
  logic        avs_waitrequest;
  logic        fault_valid;
  logic [31:0] fault_linear_addr;
  logic [31:0] fault_error_code;
  logic        handler_invoke;
  logic        task_switch;
  logic [31:0] task_dir_base;
  logic [1:0]  attr_src;
  logic [1:0]  dir_entry_attr;
  logic [1:0]  tbl_entry_attr;
  logic        dir_entry_update;
  logic        ext_page_access;
  logic        page_cache_disable;
  logic        page_write_through;
  logic        tlb_flush;
  logic [31:0] dir_phys_addr;
  logic [31:0] global_base_out;
  logic [31:0] interrupt_base_out;
  logic        table_translate;
  logic        err_push_valid;
  logic [31:0] err_push_data;
  logic [15:0] local_selector_out;
  logic [15:0] task_selector_out;
  logic [31:0] rd;
  logic [1:0]  rsp;
  int          n_errors;
  int          compares;
  int          n_flush = 0;
  int          f0;

  psar_regs dut (
    .clk(clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_response(avs_response),
    .avs_waitrequest(avs_waitrequest), .fault_valid(fault_valid),
    .fault_linear_addr(fault_linear_addr), .fault_error_code(fault_error_code),
    .handler_invoke(handler_invoke), .task_switch(task_switch),
    .task_dir_base(task_dir_base), .attr_src(attr_src), .dir_entry_attr(dir_entry_attr),
    .tbl_entry_attr(tbl_entry_attr), .dir_entry_update(dir_entry_update),
    .ext_page_access(ext_page_access), .page_cache_disable(page_cache_disable),
    .page_write_through(page_write_through), .tlb_flush(tlb_flush),
    .dir_phys_addr(dir_phys_addr), .global_base_out(global_base_out),
    .interrupt_base_out(interrupt_base_out), .table_translate(table_translate),
    .err_push_valid(err_push_valid), .err_push_data(err_push_data),
    .local_selector_out(local_selector_out), .task_selector_out(task_selector_out)
  );

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Flush pulses last one cycle, so they are counted here rather than polled.
  always @(posedge clk) begin
    if (tlb_flush === 1'b1) begin
      n_flush <= n_flush + 1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Values read right after an edge are those the slave showed at that edge, so the
  // answer is taken at the very edge where waitrequest is low; only the watchdog ends a hang.
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_read      <= !wr;
    avs_write     <= wr;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rd        = avs_readdata;
    rsp       = avs_response;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr_rd(input logic [5:0] a, input logic [31:0] d, input logic [31:0] e);
    bus(1'b1, a, d);
    bus(1'b0, a, 32'h0);
    check(rd, e);
  endtask

  // Kind 0 is a fault, 1 a handler start, 2 a task switch.
  task automatic ev(input int k, input logic [31:0] v);
    @(posedge clk);
    fault_linear_addr <= v;
    fault_error_code  <= v;
    task_dir_base     <= v;
    fault_valid       <= (k == 0);
    handler_invoke    <= (k == 1);
    task_switch       <= (k == 2);
    @(posedge clk);
    fault_valid    <= 1'b0;
    handler_invoke <= 1'b0;
    task_switch    <= 1'b0;
  endtask

  task automatic pins(input logic [1:0] s, de, te, input logic u, input logic [1:0] e);
    @(posedge clk);
    attr_src         <= s;
    dir_entry_attr   <= de;
    tbl_entry_attr   <= te;
    dir_entry_update <= u;
    repeat (3) @(posedge clk);
    @(negedge clk);
    check({30'h0, page_cache_disable, page_write_through}, {30'h0, e});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #20000;
    n_errors++;
    print_verdict();
  end

  initial begin
    {nrst, avs_address, avs_read, avs_write, avs_writedata} = '0;
    {fault_valid, fault_linear_addr, fault_error_code, handler_invoke} = '0;
    {task_switch, task_dir_base, attr_src, dir_entry_attr, tbl_entry_attr} = '0;
    dir_entry_update = 1'b0;
    ext_page_access  = 1'b1;
    avs_byteenable   = 4'hF;
    n_errors = 0;
    compares = 0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      bus(1'b0, 6'(i * 4), 32'h0);
      check(rd, 32'h0);
      check({30'h0, rsp}, 32'h0);
    end
    f0 = n_flush;
    wr_rd(`PSAR_OFS_DIR_BASE, 32'hFFFFFFFF, 32'hFFFFF018);
    bus(1'b1, `PSAR_OFS_DIR_BASE, 32'hFFFFFFFF);
    repeat (3) @(posedge clk);
    check(32'(n_flush - f0), 32'h2);
    check(dir_phys_addr, 32'hFFFFF000);
    f0 = n_flush;
    ev(2, 32'h12345FFF);
    ev(2, 32'h12345FFF);
    repeat (3) @(posedge clk);
    check(32'(n_flush - f0), 32'h1);
    wr_rd(`PSAR_OFS_DIR_BASE, 32'h0, 32'h0);
    ev(2, 32'h12345FFF);
    bus(1'b0, `PSAR_OFS_DIR_BASE, 32'h0);
    check(rd, 32'h12345018);
    wr_rd(`PSAR_OFS_GLOBAL_BASE, 32'hC0DE1234, 32'hC0DE1234);
    wr_rd(`PSAR_OFS_GLOBAL_LIMIT, 32'hFFFF8765, 32'h00008765);
    wr_rd(`PSAR_OFS_INTR_BASE, 32'h89ABCDEF, 32'h89ABCDEF);
    wr_rd(`PSAR_OFS_INTR_LIMIT, 32'hFFFF4321, 32'h00004321);
    check(global_base_out, 32'hC0DE1234);
    check(interrupt_base_out, 32'h89ABCDEF);
    wr_rd(`PSAR_OFS_LOCAL_SEL, 32'hFFFFABCD, 32'h0000ABCD);
    wr_rd(`PSAR_OFS_TASK_SEL, 32'hFFFF5A5A, 32'h00005A5A);
    check({16'h0, local_selector_out}, 32'h0000ABCD);
    check({16'h0, task_selector_out}, 32'h00005A5A);
    ev(0, 32'hA5A50001);
    ev(0, 32'h5A5AFFFE);
    bus(1'b0, `PSAR_OFS_FAULT_ADDR, 32'h0);
    check(rd, 32'h5A5AFFFE);
    ev(1, 32'h0000BEEF);
    @(negedge clk);
    check({err_push_valid, 31'h0}, 32'h80000000);
    check(err_push_data, 32'h0000BEEF);
    @(negedge clk);
    check({31'h0, err_push_valid}, 32'h0);
    // Paging is still off here, so the stored attribute bits must not reach the pins.
    pins(2'h0, 2'h0, 2'h0, 1'b0, 2'b00);
    pins(2'h2, 2'h3, 2'h3, 1'b0, 2'b00);
    check({31'h0, table_translate}, 32'h0);
    bus(1'b1, `PSAR_OFS_CONTROL, 32'h1);
    @(negedge clk);
    check({31'h0, table_translate}, 32'h1);
    pins(2'h0, 2'h0, 2'h0, 1'b0, 2'b11);
    pins(2'h1, 2'h2, 2'h1, 1'b0, 2'b10);
    pins(2'h2, 2'h2, 2'h1, 1'b0, 2'b01);
    pins(2'h1, 2'h2, 2'h1, 1'b1, 2'b11);
    bus(1'b1, `PSAR_OFS_DIR_BASE, 32'h00001008);
    pins(2'h0, 2'h2, 2'h1, 1'b0, 2'b01);
    // Without a page access the pins must keep the last driven attributes.
    @(posedge clk);
    ext_page_access <= 1'b0;
    pins(2'h2, 2'h3, 2'h3, 1'b0, 2'b01);
    @(posedge clk);
    ext_page_access <= 1'b1;
    bus(1'b1, `PSAR_OFS_CONTROL, 32'h0);
    pins(2'h2, 2'h3, 2'h3, 1'b0, 2'b00);
    bus(1'b1, 6'h28, 32'hFFFFFFFF);
    bus(1'b0, 6'h28, 32'h0);
    check(rd, 32'h0);
    check({30'h0, rsp}, 32'h2);
    print_verdict();
  end
endmodule
